// ==== rtl/pss_consts.svh ====
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

`define PSS_CLK_NS 4
`define PSS_MISS_NS 256
`define PSS_MISS_CYC (`PSS_MISS_NS / `PSS_CLK_NS)
`define PSS_SHIFT_NS 40
`define PSS_SHIFT_CYC (`PSS_SHIFT_NS / `PSS_CLK_NS)
`define PSS_STEP_HALF_CYC 4
`define PSS_STEP_HOLD 2

`define PSS_SEL_ALL 3'h0
`define PSS_SEL_M 3'h1
`define PSS_SEL_C4 3'h6
`define PSS_MASK_ALL 6'h3e
`define PSS_MASK_ONE 6'h01

`define PSS_ADR_CTRL 8'h00
`define PSS_ADR_STEP 8'h04
`define PSS_ADR_STATUS 8'h08
`define PSS_ADR_IRQ_STAT 8'h0c
`define PSS_ADR_IRQ_CLR 8'h10
`define PSS_ADR_IRQ_EN 8'h14

`define PSS_CTRL_AUTO 0
`define PSS_CTRL_SWAP 1
`define PSS_CTRL_AUTO_RST 1'h1
`define PSS_STEP_SEL_LSB 0
`define PSS_STEP_DIR 3
`define PSS_STEP_GO 4
`define PSS_IRQ_MISS_A 0
`define PSS_IRQ_MISS_B 1
`define PSS_IRQ_ACTIVE 2
`define PSS_IRQ_STEP 3

`endif

// ==== rtl/pss_pkg.sv ====
`include "pss_consts.svh"

package pss_pkg;

    typedef logic [5:0] pss_cnt_mask_t;

    typedef enum logic [1:0] {PS_IDLE, PS_ARMED, PS_SHIFT, PS_RELEASE} pss_step_st_t;

    typedef enum logic [2:0] {CS_IDLE, CS_SETUP, CS_ASSERT, CS_WAITHI} pss_drv_st_t;

    typedef struct packed {
        logic [1:0][7:0] idle_cnt;
        logic [1:0] miss;
        logic active;
        logic done;
        pss_step_st_t st;
        logic [3:0] wait_cnt;
        logic late;
        pss_cnt_mask_t pulse;
    } pss_dev_state_t;

    typedef struct packed {
        logic [2:0] div;
        logic step_clk;
        pss_drv_st_t st;
        logic [1:0] hold;
        logic step;
        logic dir;
        logic [2:0] sel;
        logic go;
        logic go_dir;
        logic [2:0] go_sel;
        logic auto_en;
        logic swap;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [2:0] prev;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } pss_core_state_t;

    // Bit 0 is the feedback counter, bits 1..5 the output counters
    function automatic pss_cnt_mask_t pss_decode(input logic [2:0] sel);
        pss_cnt_mask_t m;
        m = '0;
        if (sel == `PSS_SEL_ALL) begin
            m = `PSS_MASK_ALL;
        end else if (sel <= `PSS_SEL_C4) begin
            m = pss_cnt_mask_t'(`PSS_MASK_ONE << (sel - `PSS_SEL_M));
        end
        return m;
    endfunction

endpackage

// ==== rtl/pss_link_if.sv ====
`timescale 1ns/1ps

interface pss_link_if;
    logic switch_req;
    logic auto_en;
    logic step_clk;
    logic phase_step;
    logic shift_direction;
    logic [2:0] target_counter_field;
    logic ref_a_missing_flag;
    logic ref_b_missing_flag;
    logic active_ref;
    logic phase_done;

    modport dev (
        input switch_req,
        input auto_en,
        input step_clk,
        input phase_step,
        input shift_direction,
        input target_counter_field,
        output ref_a_missing_flag,
        output ref_b_missing_flag,
        output active_ref,
        output phase_done
    );

    modport core (
        output switch_req,
        output auto_en,
        output step_clk,
        output phase_step,
        output shift_direction,
        output target_counter_field,
        input ref_a_missing_flag,
        input ref_b_missing_flag,
        input active_ref,
        input phase_done
    );
endinterface

// ==== rtl/pss_sync_edge.sv ====
`timescale 1ns/1ps

module pss_sync_edge (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic din,
    output logic rise
);
    import pss_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } pss_sync_t;

    pss_sync_t q;
    pss_sync_t d;

    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Edge only from the second and third stages
    assign rise = q.s2 & ~q.s3;
endmodule

// ==== rtl/pss_pll_ctrl.sv ====
// How it works
// RULE_01 - Reference picked from two inputs, auto or requested
// RULE_02 - Absent active reference switches to backup automatically
// RULE_03 - Missing flag per input plus active indicator
// RULE_04 - Backup on second input, primary on first
// RULE_05 - Automatic switching back and forth, unlimited times
// RULE_06 - Far-apart frequencies need commanded switchover
// RULE_07 - Core supplies free-running step clock
// RULE_08 - Done rises when step finishes, falls on step edge
// RULE_09 - Select field decodes all, feedback, C0 to C4
// RULE_10 - Direction and select set before each step
// RULE_11 - Request held two step cycles, one shift each
// RULE_12 - Request released only after done goes low
// RULE_13 - Next step waits for done high again
// RULE_14 - Direction and select driven on step clock
// RULE_15 - Direction high means later phase, low earlier
// RULE_16 - Active indicator low for first, high for second
`timescale 1ns/1ps
`include "pss_consts.svh"

module pss_pll_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    pss_link_if.dev link,
    input wire logic primary_ref_input,
    input wire logic backup_ref_input,
    output logic ref_sel,
    output pss_pkg::pss_cnt_mask_t cnt_step,
    output logic step_late
);
    import pss_pkg::*;

    localparam logic [7:0] MISS_LAST = 8'(`PSS_MISS_CYC - 1);
    localparam logic [3:0] SHIFT_LAST = 4'(`PSS_SHIFT_CYC - 1);

    pss_dev_state_t q;
    pss_dev_state_t d;
    logic [1:0] ref_rise;
    logic step_rise;
    logic alt;

    // Reference inputs come from outside this clock and are resynchronised
    pss_sync_edge u_sync_ref_a (
        .core_clk(core_clk),
        .rst(rst),
        .din(primary_ref_input),
        .rise(ref_rise[0])
    );

    pss_sync_edge u_sync_ref_b (
        .core_clk(core_clk),
        .rst(rst),
        .din(backup_ref_input),
        .rise(ref_rise[1])
    );

    pss_sync_edge u_sync_step (
        .core_clk(core_clk),
        .rst(rst),
        .din(link.step_clk),
        .rise(step_rise)
    );

    always_comb begin
        d = q;
        d.pulse = '0;
        alt = ~q.active;

        // Clock sense: an input with no edge for the timeout is absent
        for (int i = 0; i < 2; i++) begin
            if (ref_rise[i]) begin
                d.idle_cnt[i] = '0;
                d.miss[i] = 1'b0;
            end else if (q.idle_cnt[i] == MISS_LAST) begin
                d.miss[i] = 1'b1; // [RULE_03]
            end else begin
                d.idle_cnt[i] = q.idle_cnt[i] + 8'h01;
            end
        end

        // A commanded swap wins over the automatic decision
        if (link.switch_req) begin
            d.active = alt; // [RULE_01]
        end else if (link.auto_en && q.miss[q.active] && !q.miss[alt]) begin
            // Either direction, any number of times [RULE_02] [RULE_05]
            d.active = alt; // [RULE_01]
        end

        case (q.st)
            PS_IDLE: begin
                if (step_rise && link.phase_step) begin
                    d.st = PS_ARMED;
                end
            end
            PS_ARMED: begin
                // Second step edge with the request still high starts one shift
                if (step_rise) begin
                    if (link.phase_step) begin
                        d.st = PS_SHIFT;
                        d.done = 1'b0; // [RULE_08]
                        d.late = link.shift_direction; // [RULE_15]
                        d.pulse = pss_decode(link.target_counter_field); // [RULE_09]
                        d.wait_cnt = '0;
                    end else begin
                        // Too short a request is dropped, no shift
                        d.st = PS_IDLE;
                    end
                end
            end
            PS_SHIFT: begin
                if (q.wait_cnt == SHIFT_LAST) begin
                    d.st = PS_RELEASE;
                end else begin
                    d.wait_cnt = q.wait_cnt + 4'h1;
                end
            end
            PS_RELEASE: begin
                // Done only after release, so one request gives one shift
                if (step_rise && !link.phase_step) begin
                    d.done = 1'b1; // [RULE_08]
                    d.st = PS_IDLE;
                end
            end
            default: begin
                d.st = PS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.done <= 1'b1;
            q.st <= PS_IDLE;
        end else begin
            q <= d;
        end
    end

    assign link.ref_a_missing_flag = q.miss[0]; // [RULE_03]
    assign link.ref_b_missing_flag = q.miss[1]; // [RULE_03]
    assign link.active_ref = q.active; // [RULE_16]
    assign link.phase_done = q.done;
    assign ref_sel = q.active; // [RULE_16]
    assign cnt_step = q.pulse;
    assign step_late = q.late; // [RULE_15]
endmodule

// ==== rtl/pss_core_ctrl.sv ====
`timescale 1ns/1ps
`include "pss_consts.svh"

module pss_core_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    pss_link_if.core link,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq
);
    import pss_pkg::*;

    localparam logic [2:0] DIV_LAST = 3'(`PSS_STEP_HALF_CYC - 1);
    localparam logic [1:0] HOLD_MIN = 2'(`PSS_STEP_HOLD);

    pss_core_state_t q;
    pss_core_state_t d;
    logic access;
    logic wr;
    logic fall;
    logic [2:0] now;
    logic [3:0] set;

    always_comb begin
        d = q;
        access = wb_cyc_i && wb_stb_i && !q.ack;
        wr = access && wb_we_i && wb_sel_i[0];
        now = {link.active_ref, link.ref_b_missing_flag, link.ref_a_missing_flag};
        set = '0;
        d.swap = 1'b0;

        // Free-running step clock, 8 core cycles per period [RULE_07]
        fall = (q.div == DIV_LAST) && q.step_clk;
        if (q.div == DIV_LAST) begin
            d.div = '0;
            d.step_clk = ~q.step_clk;
        end else begin
            d.div = q.div + 3'h1;
        end

        // Controls change on the falling step edge, stable at the rising [RULE_14]
        case (q.st)
            CS_IDLE: begin
                if (q.go && fall) begin
                    d.go = 1'b0;
                    d.dir = q.go_dir; // [RULE_10]
                    d.sel = q.go_sel; // [RULE_10]
                    d.st = CS_SETUP;
                end
            end
            CS_SETUP: begin
                if (fall) begin
                    d.step = 1'b1;
                    d.hold = '0;
                    d.st = CS_ASSERT;
                end
            end
            CS_ASSERT: begin
                if (fall) begin
                    if (q.hold != HOLD_MIN) begin
                        d.hold = q.hold + 2'h1;
                    end
                    if (q.hold == HOLD_MIN && !link.phase_done) begin
                        d.step = 1'b0; // [RULE_11] [RULE_12]
                        d.st = CS_WAITHI;
                    end
                end
            end
            CS_WAITHI: begin
                if (link.phase_done) begin
                    set[`PSS_IRQ_STEP] = 1'b1; // [RULE_13]
                    d.st = CS_IDLE;
                end
            end
            default: begin
                d.st = CS_IDLE;
            end
        endcase

        set[`PSS_IRQ_MISS_A] = now[0] & ~q.prev[0];
        set[`PSS_IRQ_MISS_B] = now[1] & ~q.prev[1];
        set[`PSS_IRQ_ACTIVE] = now[2] ^ q.prev[2];
        d.prev = now;

        d.ack = access;
        d.dat = '0;
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                `PSS_ADR_CTRL: d.dat = {31'h0, q.auto_en};
                `PSS_ADR_STEP: d.dat = {27'h0, q.go, q.go_dir, q.go_sel};
                `PSS_ADR_STATUS: d.dat = {27'h0, link.phase_done,
                                          q.go || q.st != CS_IDLE, now};
                `PSS_ADR_IRQ_STAT: d.dat = {28'h0, q.irq_stat};
                `PSS_ADR_IRQ_EN: d.dat = {28'h0, q.irq_en};
                default: d.dat = '0;
            endcase
        end

        d.irq_stat = q.irq_stat | set;
        if (wr) begin
            case (wb_adr_i)
                `PSS_ADR_CTRL: begin
                    d.auto_en = wb_dat_i[`PSS_CTRL_AUTO];
                    // Needed when the inputs run at widely differing rates [RULE_06]
                    d.swap = wb_dat_i[`PSS_CTRL_SWAP];
                end
                `PSS_ADR_STEP: begin
                    // A new step is refused while one is pending or running
                    if (wb_dat_i[`PSS_STEP_GO] && !q.go && q.st == CS_IDLE) begin
                        d.go = 1'b1;
                        d.go_dir = wb_dat_i[`PSS_STEP_DIR];
                        d.go_sel = wb_dat_i[`PSS_STEP_SEL_LSB +: 3];
                    end
                end
                // Set wins over clear
                `PSS_ADR_IRQ_CLR: d.irq_stat = (q.irq_stat & ~wb_dat_i[3:0]) | set;
                `PSS_ADR_IRQ_EN: d.irq_en = wb_dat_i[3:0];
                default: d.irq_en = q.irq_en;
            endcase
        end
        d.irq = |(d.irq_stat & d.irq_en);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.auto_en <= `PSS_CTRL_AUTO_RST;
            q.st <= CS_IDLE;
        end else begin
            q <= d;
        end
    end

    assign link.switch_req = q.swap; // [RULE_06]
    assign link.auto_en = q.auto_en;
    assign link.step_clk = q.step_clk; // [RULE_07]
    assign link.phase_step = q.step;
    assign link.shift_direction = q.dir; // [RULE_14]
    assign link.target_counter_field = q.sel; // [RULE_14]
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign irq = q.irq;
endmodule

// ==== tb/pss_link_asserts.sv ====
`timescale 1ns/1ps

module pss_link_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic switch_req,
    input wire logic auto_en,
    input wire logic step_clk,
    input wire logic phase_step,
    input wire logic shift_direction,
    input wire logic [2:0] target_counter_field,
    input wire logic ref_a_missing_flag,
    input wire logic ref_b_missing_flag,
    input wire logic active_ref,
    input wire logic phase_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic cur_bad;
    logic alt_bad;
    assign cur_bad = active_ref ? ref_b_missing_flag : ref_a_missing_flag;
    assign alt_bad = active_ref ? ref_a_missing_flag : ref_b_missing_flag;

    a_swap_toggles: assert property (switch_req |=> active_ref != $past(active_ref))
        else $error("requested swap did not move active input");
    a_auto_moves: assert property (auto_en && !switch_req && cur_bad && !alt_bad
        |=> active_ref != $past(active_ref))
        else $error("lost reference not replaced");
    a_active_holds: assert property (!switch_req && !(auto_en && cur_bad && !alt_bad)
        |=> $stable(active_ref))
        else $error("active input moved without cause");
    a_step_clk_shape: assert property ($rose(step_clk) |-> step_clk[*4] ##1 !step_clk[*4])
        else $error("step clock not 4 high 4 low");
    a_done_needs_req: assert property ($fell(phase_done) |-> phase_step && $past(phase_step, 8))
        else $error("done fell without a held request");
    a_done_low_min: assert property ($fell(phase_done) |-> !phase_done[*8])
        else $error("done came back before shift time");
    a_done_returns: assert property ($fell(phase_done) |-> ##[1:200] phase_done)
        else $error("done never returned");
    a_done_rise_idle: assert property ($rose(phase_done) |-> !phase_step)
        else $error("done rose while request held");
    a_release_late: assert property ($fell(phase_step) |-> !phase_done)
        else $error("request dropped before done went low");
    a_ctl_steady: assert property (phase_step && $past(phase_step)
        |-> $stable({shift_direction, target_counter_field}))
        else $error("direction or select changed during request");
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "pss_consts.svh"

module testbench;
    import pss_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] sel = 4'h0, wsel = 4'hf;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, irq, ref_sel, step_late;
    logic ref_a = 1'b0, ref_b = 1'b0, run_a = 1'b1, run_b = 1'b1;
    logic [1:0] div = 2'h0;
    pss_cnt_mask_t cnt_step, mask_seen = 6'h00;
    int failures = 0, samples_checked = 0, pulses = 0;

    pss_link_if link();

    always #2 core_clk = ~core_clk;

    // Stopped references sit low, as a dead oscillator would
    always @(posedge core_clk) begin
        div <= div + 2'h1;
        ref_a <= run_a & div[1];
        ref_b <= run_b & div[1];
        if (cnt_step !== 6'h00) begin
            mask_seen <= cnt_step;
            pulses <= pulses + 1;
        end
    end

    pss_pll_ctrl pss_pll_ctrl_inst (.core_clk(core_clk), .rst(rst), .link(link.dev),
        .primary_ref_input(ref_a), .backup_ref_input(ref_b), .ref_sel(ref_sel),
        .cnt_step(cnt_step), .step_late(step_late));
    pss_core_ctrl pss_core_ctrl_inst (.core_clk(core_clk), .rst(rst), .link(link.core),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq));
    pss_link_asserts pss_link_asserts_inst (.core_clk(core_clk), .rst(rst),
        .switch_req(link.switch_req), .auto_en(link.auto_en), .step_clk(link.step_clk),
        .phase_step(link.phase_step), .shift_direction(link.shift_direction),
        .target_counter_field(link.target_counter_field),
        .ref_a_missing_flag(link.ref_a_missing_flag),
        .ref_b_missing_flag(link.ref_b_missing_flag),
        .active_ref(link.active_ref), .phase_done(link.phase_done));

    task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        wdat <= d;
        @(posedge core_clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 50) failures++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(s, q, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task conclude;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] v;
        int n;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rd("ctrl reset", `PSS_ADR_CTRL, 32'h1);
        rd("status reset", `PSS_ADR_STATUS, 32'h10);
        rd("unmapped", 8'h20, 32'h0);
        wr(`PSS_ADR_IRQ_EN, 32'hf);
        wr(`PSS_ADR_CTRL, 32'h3);
        idle(4);
        check("ref_sel swap", ref_sel, 1'b1);
        rd("swap status", `PSS_ADR_STATUS, 32'h14);
        rd("swap events", `PSS_ADR_IRQ_STAT, 32'h4);
        check("irq on", irq, 1'b1);
        wr(`PSS_ADR_IRQ_CLR, 32'hf);
        idle(2);
        check("irq off", irq, 1'b0);
        run_b <= 1'b0;
        idle(100);
        rd("auto to a", `PSS_ADR_STATUS, 32'h12);
        rd("b lost events", `PSS_ADR_IRQ_STAT, 32'h6);
        wr(`PSS_ADR_IRQ_EN, 32'h0);
        idle(2);
        check("irq masked", irq, 1'b0);
        rd("irq en off", `PSS_ADR_IRQ_EN, 32'h0);
        // Byte lane 0 off: the write is acked but must not land
        wsel = 4'he;
        wr(`PSS_ADR_IRQ_EN, 32'hf);
        wsel = 4'hf;
        rd("sel refused", `PSS_ADR_IRQ_EN, 32'h0);
        check("irq still masked", irq, 1'b0);
        wr(`PSS_ADR_IRQ_EN, 32'hf);
        wr(`PSS_ADR_IRQ_CLR, 32'hf);
        run_b <= 1'b1;
        idle(20);
        run_a <= 1'b0;
        idle(100);
        rd("auto to b", `PSS_ADR_STATUS, 32'h15);
        rd("a lost events", `PSS_ADR_IRQ_STAT, 32'h5);
        run_b <= 1'b0;
        idle(100);
        rd("both lost", `PSS_ADR_STATUS, 32'h17);
        run_a <= 1'b1;
        run_b <= 1'b1;
        idle(20);
        wr(`PSS_ADR_CTRL, 32'h0);
        run_b <= 1'b0;
        idle(100);
        rd("auto off", `PSS_ADR_STATUS, 32'h16);
        wr(`PSS_ADR_CTRL, 32'h2);
        idle(4);
        check("ref_sel manual", ref_sel, 1'b0);
        rd("manual status", `PSS_ADR_STATUS, 32'h12);
        run_b <= 1'b1;
        wr(`PSS_ADR_CTRL, 32'h1);
        wr(`PSS_ADR_IRQ_CLR, 32'hf);
        idle(20);
        // Select 7 names no counter: a full handshake but no pulse
        for (int i = 0; i < 8; i++) begin
            v = 32'h10 | (32'(i[0]) << 3) | 32'(i);
            wr(`PSS_ADR_STEP, v);
            // Second go lands while the first is pending and must be dropped
            wr(`PSS_ADR_STEP, v);
            v = 32'h0;
            n = 0;
            while (v[`PSS_IRQ_STEP] !== 1'b1 && n < 200) begin
                bus(1'b0, `PSS_ADR_IRQ_STAT, 32'h0, v);
                n++;
            end
            check("step done", v[`PSS_IRQ_STEP], 1'b1);
            wr(`PSS_ADR_IRQ_CLR, 32'h8);
            check("mask", 32'(mask_seen),
                (i == 0) ? 32'h3e : (i == 7) ? 32'h20 : 32'h1 << (i - 1));
            check("pulses", 32'(pulses), 32'((i == 7) ? i : i + 1));
            check("late", step_late, i[0]);
            rd("step idle", `PSS_ADR_STATUS, 32'h10);
        end
        conclude();
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        failures++;
        conclude();
    end
endmodule
